// File: logic/mam_cfg_scatter.sv
// Scatter of packed configuration words into configuration registers
`timescale 1ns/1ps
module mam_cfg_scatter (
  // Packed words
  input  wire logic [47:0] packedCfg,
  // Configuration registers
  output logic [15:0]      cfgRegA,
  output logic [15:0]      cfgRegB,
  output logic [15:0]      cfgRegC
);
  // Stored order deliberately differs from register order
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      cfgRegA[i] = packedCfg[3*i];
      cfgRegB[i] = packedCfg[3*i+1];
      cfgRegC[i] = packedCfg[3*i+2];
    end
  end
endmodule : mam_cfg_scatter

// File: logic/mam_mem_map.sv
// Memory map, data byte lanes, program word view and configuration loader
// Notes on behaviour
// - Program location: lower word even address, upper word odd, top byte absent.
// - Program counter stays on lower word, steps by two up or down.
// - Program addresses below 000200h are reserved for vectors.
// - Primary vector table 000004h-0000FFh, alternate 000100h-0001FFh.
// - Every reset copies top three program words into configuration registers.
// - Packed configuration bits are scattered in a different order.
// - Data addresses are 16-bit byte addresses, 64 Kbytes.
// - Address bit 15 selects data memory or program visibility window.
// - 16 Kbytes implemented; reads elsewhere return zero.
// - Separate read and write address generators.
// - Low byte at even address, high byte at odd address.
// - Post-increment adds one for bytes, two for words.
// - Byte read fetches word, selects by bit zero, delivers low.
// - Shared word decode, separate byte write strobes.
// - Misaligned word access raises an address error trap.
// - Misaligned read completes; misaligned write suppressed; trap follows.
// - Byte load changes only the working register low byte.
// - Sign extend and zero extend operations on working data.
// - Unused special function register addresses read zero.
`timescale 1ns/1ps
module mam_mem_map
  import mam_pkg::*;
#(
  parameter int DATA_BYTES_P = mam_pkg::DATA_BYTES,
  parameter int SFR_MAP_P    = 64
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Program counter control
  input  wire logic        pcStep,
  input  wire logic        pcDown,
  input  wire logic        pcLoad,
  input  wire logic [23:0] pcLoadValue,
  // Program memory word view
  input  wire logic [23:0] progAddr,
  input  wire logic [23:0] progWord,
  // Configuration load from flash
  input  wire logic [47:0] cfgFlash,
  // Read address generator
  input  wire logic        rdReq,
  input  wire logic        rdByte,
  input  wire logic        rdPostInc,
  input  wire logic [15:0] rdAddr,
  input  wire logic [15:0] rdWord,
  input  wire logic        sfrHit,
  // Write address generator
  input  wire logic        wrReq,
  input  wire logic        wrByte,
  input  wire logic        wrPostInc,
  input  wire logic [15:0] wrAddr,
  input  wire logic [15:0] wrData,
  // Working register update
  input  wire logic        wregLoad,
  input  wire logic [1:0]  wregOp,
  input  wire logic [15:0] wregOld,
  // Program outputs
  output logic [23:0]      pcOut_q,
  output logic [15:0]      progHalf_q,
  output logic             progVector_q,
  output logic             progIvtAlt_q,
  // Configuration outputs
  output logic [15:0]      cfgRegA_q,
  output logic [15:0]      cfgRegB_q,
  output logic [15:0]      cfgRegC_q,
  output logic             cfgValid_q,
  // Data read outputs
  output logic [15:0]      rdData_q,
  output logic             rdValid_q,
  output logic             rdPsv_q,
  output logic [15:0]      rdAddrNext_q,
  // Data write outputs
  output logic [14:0]      wrWordAddr_q,
  output logic [15:0]      wrDataOut_q,
  output logic             wrStrobeLo_q,
  output logic             wrStrobeHi_q,
  output logic [15:0]      wrAddrNext_q,
  // Working register result and trap
  output logic [15:0]      wregNew_q,
  output logic             addrErrTrap_q
);
  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (DATA_BYTES_P < 2 || DATA_BYTES_P > 32768 || (DATA_BYTES_P % 2) != 0) begin : g_chk
    $error("DATA_BYTES_P out of range");
  end
  if (SFR_MAP_P < 1 || SFR_MAP_P > 2048) begin : g_chk2
    $error("SFR_MAP_P out of range");
  end

  localparam logic [1:0]  WOP_BYTE = 2'b00;
  localparam logic [1:0]  WOP_SE   = 2'b01;
  localparam logic [1:0]  WOP_ZE   = 2'b10;
  localparam logic [15:0] IMPL_TOP = 16'(DATA_BYTES_P);

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pcOut_q <= PROG_RESET_ADR;
    end else if (pcLoad) begin
      pcOut_q <= {pcLoadValue[23:1], 1'b0};
    end else if (pcStep) begin
      pcOut_q <= pcDown ? pcOut_q - PC_STEP : pcOut_q + PC_STEP;
    end
  end

  // ---------------------------------------------------------------
  // Program word view and vector decode
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      progHalf_q   <= 16'h0000;
      progVector_q <= 1'b0;
      progIvtAlt_q <= 1'b0;
    end else begin
      // Odd address is the upper word; its top byte reads zero
      progHalf_q   <= progAddr[0] ? {8'h00, progWord[23:16]} : progWord[15:0];
      progVector_q <= progAddr < VECTOR_END;
      progIvtAlt_q <= progAddr >= IVT_ALT_LO && progAddr <= IVT_ALT_HI;
    end
  end

  // ---------------------------------------------------------------
  // Configuration loader
  // ---------------------------------------------------------------
  mam_cfg_e    cfgState_q;
  logic [15:0] scatA;
  logic [15:0] scatB;
  logic [15:0] scatC;

  mam_cfg_scatter u_scatter (
    .packedCfg (cfgFlash),
    .cfgRegA   (scatA),
    .cfgRegB   (scatB),
    .cfgRegC   (scatC)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfgState_q <= CFG_IDLE;
    end else begin
      case (cfgState_q)
        CFG_IDLE: cfgState_q <= CFG_READ;
        CFG_READ: cfgState_q <= CFG_DONE;
        CFG_DONE: cfgState_q <= CFG_DONE;
        default:  cfgState_q <= CFG_IDLE;
      endcase
    end
  end

  // Flash is sampled after release so a reset always reloads it
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfgRegA_q  <= 16'h0000;
      cfgRegB_q  <= 16'h0000;
      cfgRegC_q  <= 16'h0000;
      cfgValid_q <= 1'b0;
    end else if (cfgState_q == CFG_READ) begin
      cfgRegA_q  <= scatA;
      cfgRegB_q  <= scatB;
      cfgRegC_q  <= scatC;
      cfgValid_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read address generator
  // ---------------------------------------------------------------
  logic        rdImpl;
  logic        rdSfrHole;
  logic        rdMis;
  logic [15:0] rdSel;
  assign rdImpl    = !rdAddr[EA_PSV_BIT] && rdAddr < IMPL_TOP;
  assign rdSfrHole = rdAddr <= SFR_LAST && !sfrHit;
  assign rdMis     = !rdByte && rdAddr[0];
  // Byte reads take the addressed lane down to the low byte
  assign rdSel     = rdByte ? {8'h00, (rdAddr[0] ? rdWord[15:8] : rdWord[7:0])}
                            : rdWord;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdData_q     <= 16'h0000;
      rdValid_q    <= 1'b0;
      rdPsv_q      <= 1'b0;
      rdAddrNext_q <= 16'h0000;
    end else begin
      rdValid_q <= rdReq;
      rdPsv_q   <= rdReq && rdAddr[EA_PSV_BIT];
      if (rdReq) begin
        // Misaligned reads still complete; trap raised separately
        rdData_q     <= (rdImpl && !rdSfrHole) ? rdSel : 16'h0000;
        rdAddrNext_q <= rdPostInc ? rdAddr + (rdByte ? STEP_BYTE : STEP_WORD)
                                  : rdAddr;
      end
    end
  end

  // ---------------------------------------------------------------
  // Write address generator
  // ---------------------------------------------------------------
  logic wrMis;
  logic wrOk;
  assign wrMis = !wrByte && wrAddr[0];
  assign wrOk  = wrReq && !wrMis && !wrAddr[EA_PSV_BIT] && wrAddr < IMPL_TOP;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wrWordAddr_q <= 15'h0000;
      wrDataOut_q  <= 16'h0000;
      wrStrobeLo_q <= 1'b0;
      wrStrobeHi_q <= 1'b0;
      wrAddrNext_q <= 16'h0000;
    end else begin
      wrStrobeLo_q <= wrOk && (!wrByte || !wrAddr[0]);
      wrStrobeHi_q <= wrOk && (!wrByte || wrAddr[0]);
      if (wrReq) begin
        wrWordAddr_q <= wrAddr[15:1];
        wrDataOut_q  <= wrByte ? {wrData[7:0], wrData[7:0]} : wrData;
        wrAddrNext_q <= wrPostInc ? wrAddr + (wrByte ? STEP_BYTE : STEP_WORD)
                                  : wrAddr;
      end
    end
  end

  // ---------------------------------------------------------------
  // Address error trap, one pulse after the faulting access
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      addrErrTrap_q <= 1'b0;
    end else begin
      addrErrTrap_q <= (rdReq && rdMis) || (wrReq && wrMis);
    end
  end

  // ---------------------------------------------------------------
  // Working register byte load and extend
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wregNew_q <= 16'h0000;
    end else if (wregLoad) begin
      case (wregOp)
        WOP_BYTE: wregNew_q <= {wregOld[15:8], rdSel[7:0]};
        WOP_SE:   wregNew_q <= {{8{wregOld[7]}}, wregOld[7:0]};
        WOP_ZE:   wregNew_q <= {8'h00, wregOld[7:0]};
        default:  wregNew_q <= rdSel;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_pc_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pcStep && !pcLoad && !pcDown |=> pcOut_q == $past(pcOut_q) + PC_STEP)
    else $error("pc step wrong");
  a_rd_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rdReq && rdAddr[EA_PSV_BIT] |=> rdData_q == 16'h0000 && rdPsv_q)
    else $error("outside read not zero");
  a_mis_trap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrReq && !wrByte && wrAddr[0] |=> addrErrTrap_q && !wrStrobeLo_q && !wrStrobeHi_q)
    else $error("misaligned write not suppressed");
  a_rd_trap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rdReq && !rdByte && rdAddr[0] |=> addrErrTrap_q && rdValid_q)
    else $error("misaligned read trap missing");
  a_byte_lane: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrStrobeLo_q && wrStrobeHi_q |-> !$past(wrByte))
    else $error("byte write hit both lanes");
  a_post_inc: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rdReq && rdPostInc && rdByte |=> rdAddrNext_q == $past(rdAddr) + STEP_BYTE)
    else $error("byte post increment wrong");
  a_cfg_load: assert property (@(posedge ref_clk)
    !rst_b ##1 rst_b [*2] |=> cfgValid_q)
    else $error("configuration not loaded");
  a_byte_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wregLoad && wregOp == WOP_BYTE |=> wregNew_q[15:8] == $past(wregOld[15:8]))
    else $error("byte load changed high byte");
  a_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    progAddr[0] |=> progHalf_q == {8'h00, $past(progWord[23:16])})
    else $error("upper byte not zero");
endmodule : mam_mem_map

// File: logic/mam_pkg.sv
// Package: memory map, byte lane and configuration loader constants
package mam_pkg;
  // ---------------------------------------------------------------
  // Program space
  // ---------------------------------------------------------------
  localparam int          PROG_AW        = 24;
  localparam logic [23:0] PROG_RESET_ADR = 24'h000000;
  localparam logic [23:0] PROG_JUMP_TGT  = 24'h000002;
  localparam logic [23:0] IVT_PRI_LO     = 24'h000004;
  localparam logic [23:0] IVT_PRI_HI     = 24'h0000ff;
  localparam logic [23:0] IVT_ALT_LO     = 24'h000100;
  localparam logic [23:0] IVT_ALT_HI     = 24'h0001ff;
  localparam logic [23:0] VECTOR_END     = 24'h000200;
  localparam logic [23:0] PC_STEP        = 24'h000002;
  localparam int          CFG_WORDS      = 3;
  localparam int          CFG_BITS       = 48;
  // ---------------------------------------------------------------
  // Data space
  // ---------------------------------------------------------------
  localparam int          DATA_AW        = 16;
  localparam int          EA_PSV_BIT     = 15;
  localparam int          DATA_BYTES     = 16384;
  localparam logic [15:0] SFR_LAST       = 16'h07ff;
  localparam logic [15:0] STEP_BYTE      = 16'h0001;
  localparam logic [15:0] STEP_WORD      = 16'h0002;
  typedef enum logic [2:0] {
    CFG_IDLE = 3'b001,
    CFG_READ = 3'b010,
    CFG_DONE = 3'b100
  } mam_cfg_e;
endpackage : mam_pkg

// File: tb/mam_cpu_model.sv
// CPU-side model: data memory behind the read generator, taking byte-lane writes
`timescale 1ns/1ps
module mam_cpu_model (
  // Clock
  input  wire logic        ref_clk,
  // Read side
  input  wire logic [15:0] rdAddr,
  output logic [15:0]      rdWord,
  output logic             sfrHit,
  // Write side
  input  wire logic [14:0] wrWordAddr_q,
  input  wire logic [15:0] wrDataOut_q,
  input  wire logic        wrStrobeLo_q,
  input  wire logic        wrStrobeHi_q
);
  logic [15:0] mem [256];
  // Never zero, so a missing zero-fill outside memory shows
  initial for (int i = 0; i < 256; i++) mem[i] = {i[7:0] ^ 8'h5a, i[7:0]};
  // Addresses alias freely; the block must hide what lies beyond its map
  assign rdWord = mem[rdAddr[8:1]];
  // Hole at 0500h-05FFh inside the register region
  assign sfrHit = (rdAddr <= 16'h07ff) && (rdAddr[10:8] != 3'h5);
  always @(posedge ref_clk) begin
    if (wrStrobeLo_q) mem[wrWordAddr_q[7:0]][7:0] <= wrDataOut_q[7:0];
    if (wrStrobeHi_q) mem[wrWordAddr_q[7:0]][15:8] <= wrDataOut_q[15:8];
  end
endmodule : mam_cpu_model

// File: tb/tb.sv
// Self-checking bench for the memory map and byte lane block
`timescale 1ns/1ps
module tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        ref_clk = 1'b0, rst_b = 1'b0, pcStep = 1'b0, pcDown = 1'b0, pcLoad = 1'b0;
  logic        rdReq = 1'b0, rdByte = 1'b0, rdPostInc = 1'b0, wregLoad = 1'b0;
  logic        wrReq = 1'b0, wrByte = 1'b0, wrPostInc = 1'b0;
  logic [1:0]  wregOp = 2'h0;
  logic [15:0] rdAddr = 16'h0000, wrAddr = 16'h0000, wrData = 16'h0000, wregOld = 16'h0000;
  logic [23:0] pcLoadValue = 24'h000000, progAddr = 24'h000000, progWord = 24'hc3a596;
  logic [47:0] cfgFlash = 48'h0;
  logic [15:0] rdWord, cfgRegA_q, cfgRegB_q, cfgRegC_q, rdData_q, rdAddrNext_q;
  logic [15:0] wrDataOut_q, wrAddrNext_q, wregNew_q, progHalf_q;
  logic [23:0] pcOut_q;
  logic [14:0] wrWordAddr_q;
  logic        sfrHit, progVector_q, progIvtAlt_q, cfgValid_q, rdValid_q, rdPsv_q;
  logic        wrStrobeLo_q, wrStrobeHi_q, addrErrTrap_q;
  int          errCount = 0;
  int          nChecks = 0;

  always #12.5 ref_clk = ~ref_clk;

  mam_mem_map dut (.ref_clk, .rst_b, .pcStep, .pcDown, .pcLoad, .pcLoadValue, .progAddr,
    .progWord, .cfgFlash, .rdReq, .rdByte, .rdPostInc, .rdAddr, .rdWord, .sfrHit, .wrReq,
    .wrByte, .wrPostInc, .wrAddr, .wrData, .wregLoad, .wregOp, .wregOld, .pcOut_q,
    .progHalf_q, .progVector_q, .progIvtAlt_q, .cfgRegA_q, .cfgRegB_q, .cfgRegC_q,
    .cfgValid_q, .rdData_q, .rdValid_q, .rdPsv_q, .rdAddrNext_q, .wrWordAddr_q,
    .wrDataOut_q, .wrStrobeLo_q, .wrStrobeHi_q, .wrAddrNext_q, .wregNew_q, .addrErrTrap_q);
  mam_cpu_model cpu (.ref_clk, .rdAddr, .rdWord, .sfrHit, .wrWordAddr_q, .wrDataOut_q,
    .wrStrobeLo_q, .wrStrobeHi_q);

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic tick();
    @(posedge ref_clk);
    #2;
  endtask : tick

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic fin(input string name);
    {rdReq, wrReq, wregLoad, pcStep, pcLoad} = 5'h00;
    tick();
    $display("test %s done", name);
  endtask : fin

  task automatic endSim();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : endSim

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic doReset(input logic [47:0] cfg);
    logic [15:0] ea, eb, ec;
    rst_b = 1'b0;
    cfgFlash = cfg;
    repeat (16) tick();
    chk("pc in reset", pcOut_q, 24'h0);
    rst_b = 1'b1;
    tick();
    chk("cfg valid early", cfgValid_q, 24'h0);
    tick();
    chk("cfg valid", cfgValid_q, 24'h1);
    for (int i = 0; i < 16; i++) begin
      ea[i] = cfg[3*i];
      eb[i] = cfg[3*i+1];
      ec[i] = cfg[3*i+2];
    end
    chk("cfg a", cfgRegA_q, ea);
    chk("cfg b", cfgRegB_q, eb);
    chk("cfg c", cfgRegC_q, ec);
    fin("reset");
  endtask : doReset

  task automatic tPc();
    logic [23:0] exp [4] = '{24'h000202, 24'h000200, 24'h0001fe, 24'h0001fe};
    pcLoad = 1'b1;
    pcLoadValue = 24'h000201;
    tick();
    chk("pc load", pcOut_q, 24'h000200);
    pcLoad = 1'b0;
    pcStep = 1'b1;
    foreach (exp[i]) begin
      pcDown = (i > 0);
      pcStep = (i < 3);
      tick();
      chk("pc step", pcOut_q, exp[i]);
    end
    fin("pc");
  endtask : tPc

  task automatic tProg();
    logic [23:0] adr [7] = '{24'h000000, 24'h000004, 24'h0000ff, 24'h000100, 24'h0001ff,
                             24'h000200, 24'h000201};
    foreach (adr[i]) begin
      progAddr = adr[i];
      tick();
      chk("prog half", progHalf_q,
          adr[i][0] ? {16'h0, progWord[23:16]} : {8'h0, progWord[15:0]});
      chk("prog vector", progVector_q, adr[i] < 24'h000200);
      chk("prog alt", progIvtAlt_q, adr[i] >= 24'h000100 && adr[i] <= 24'h0001ff);
    end
    fin("prog");
  endtask : tProg

  task automatic tData();
    {rdReq, rdByte, rdPostInc, rdAddr} = {3'b101, 16'h0202};
    {wrReq, wrByte, wrPostInc, wrAddr, wrData} = {3'b101, 16'h0100, 16'h1234};
    tick();
    chk("word strobes", {wrStrobeHi_q, wrStrobeLo_q}, 24'h3);
    chk("word addr", wrWordAddr_q, 24'h0080);
    chk("wr next word", wrAddrNext_q, 24'h0102);
    chk("rd word", rdData_q, 24'h5b01);
    chk("rd next word", rdAddrNext_q, 24'h0204);
    {rdByte, rdAddr, wrByte, wrAddr, wrData} = {1'b1, 16'h0203, 1'b1, 16'h0101, 16'h00ee};
    tick();
    chk("byte strobes", {wrStrobeHi_q, wrStrobeLo_q}, 24'h2);
    chk("byte lane", wrDataOut_q[15:8], 24'hee);
    chk("wr next byte", wrAddrNext_q, 24'h0102);
    chk("rd byte odd", rdData_q, 24'h005b);
    chk("rd next byte", rdAddrNext_q, 24'h0204);
    {rdReq, wrReq} = 2'b00;
    tick();
    {rdReq, rdByte, rdAddr} = {2'b10, 16'h0100};
    tick();
    chk("merged word", rdData_q, 24'hee34);
    rdByte = 1'b1;
    tick();
    chk("rd byte even", rdData_q, 24'h0034);
    fin("data");
  endtask : tData

  task automatic tErr();
    // Word write to an odd byte address, which software must never issue
    {wrReq, wrByte, wrPostInc, wrAddr, wrData} = {3'b100, 16'h0103, 16'hffff};
    tick();
    chk("trap on write", addrErrTrap_q, 24'h1);
    chk("no strobes", {wrStrobeHi_q, wrStrobeLo_q}, 24'h0);
    chk("wr no post step", wrAddrNext_q, 24'h0103);
    wrReq = 1'b0;
    tick();
    chk("trap one cycle", addrErrTrap_q, 24'h0);
    // A stray strobe would land at the edge before this read samples memory
    {rdReq, rdByte, rdPostInc, rdAddr} = {3'b100, 16'h0102};
    tick();
    chk("word intact", rdData_q, 24'hdb81);
    chk("rd no post step", rdAddrNext_q, 24'h0102);
    rdAddr = 16'h0103;
    tick();
    chk("trap on read", addrErrTrap_q, 24'h1);
    chk("read completes", rdValid_q, 24'h1);
    fin("misaligned");
  endtask : tErr

  task automatic tRange();
    logic [15:0] adr [5] = '{16'h8000, 16'h4000, 16'h0500, 16'h3ffe, 16'h0010};
    logic [15:0] dat [5] = '{16'h0000, 16'h0000, 16'h0000, 16'ha5ff, 16'h5208};
    {wrReq, wrByte, wrAddr} = {2'b10, 16'h8000};
    tick();
    chk("no strobe high half", {wrStrobeHi_q, wrStrobeLo_q, addrErrTrap_q}, 24'h0);
    {wrReq, rdReq, rdByte} = 3'b010;
    foreach (adr[i]) begin
      rdAddr = adr[i];
      tick();
      chk("range data", rdData_q, dat[i]);
      chk("range window", rdPsv_q, adr[i][15]);
    end
    fin("range");
  endtask : tRange

  task automatic tWreg();
    logic [1:0]  op [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [15:0] old [5] = '{16'h9a7c, 16'h1280, 16'h127f, 16'h9a80, 16'h4444};
    logic [15:0] exp [5] = '{16'h9a5b, 16'hff80, 16'h007f, 16'h0080, 16'h005b};
    // Read held on so a load sees the same byte whichever path feeds it
    {rdReq, rdByte, rdAddr} = {2'b11, 16'h0203};
    tick();
    wregLoad = 1'b1;
    foreach (op[i]) begin
      {wregOp, wregOld} = {op[i], old[i]};
      tick();
      chk("wreg result", wregNew_q, exp[i]);
    end
    fin("wreg");
  endtask : tWreg

  // ---------------------------------------------------------------
  // Sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    doReset(48'h0123456789ab);
    tPc();
    tProg();
    tData();
    tErr();
    tRange();
    tWreg();
    doReset(48'hfedcba987654);
    endSim();
  end

  initial begin
    #20000;
    errCount++;
    endSim();
  end
endmodule : tb
